// [hw/nalu_defs.svh]
// Constants for the nibble ALU datapath
// Assumes inclusion by bare name from package and modules
`ifndef NALU_DEFS_SVH
`define NALU_DEFS_SVH
`define NALU_W 4
`define NALU_IDX_W 8
`define NALU_ZERO 4'h0
`define NALU_ONE 4'h1
`define NALU_IDX_ONE 8'h01
`define NALU_IDX_RST 8'h00
`define NALU_CARRY_RST 1'b0
`define NALU_MSB 3
`endif

// [hw/nalu_pkg.sv]
// Types shared by the nibble ALU datapath
// Assumes the defines header is on the include path
`include "nalu_defs.svh"
package nalu_pkg;
    typedef enum logic [2:0]
    {
        NALU_ADD = 3'b000,
        NALU_SUB = 3'b001,
        NALU_AND = 3'b010,
        NALU_XOR = 3'b011,
        NALU_OR = 3'b100
    } nalu_op_t;
    // Carry-in select
    typedef enum logic [1:0]
    {
        NALU_CIN_ZERO = 2'b00,
        NALU_CIN_ONE = 2'b01,
        NALU_CIN_FLAG = 2'b10
    } nalu_cin_t;
    // Source of the second operand
    typedef enum logic [1:0]
    {
        NALU_SRC_DIRECT = 2'b00,
        NALU_SRC_INDEX = 2'b01,
        NALU_SRC_IMM = 2'b10
    } nalu_src_t;
endpackage

// [hw/nalu_core.sv]
// Nibble adder and logic unit, purely combinational
// Assumes operands are already selected by the caller
`timescale 1ns/1ns
`include "nalu_defs.svh"
module nalu_core
    import nalu_pkg::*;
(
    // Operation
    input wire nalu_op_t op,
    input wire logic invert_b,
    input wire logic cin,
    // Operands
    input wire logic [`NALU_W-1:0] a,
    input wire logic [`NALU_W-1:0] b,
    // Result
    output logic [`NALU_W-1:0] result,
    output logic cout
);
    logic [`NALU_W-1:0] b_eff;
    logic [`NALU_W:0] sum;

    assign b_eff = invert_b ? ~b : b;
    assign sum = {1'b0, a} + {1'b0, b_eff} + {{`NALU_W{1'b0}}, cin};

    always_comb
    begin
        cout = sum[`NALU_W];
        unique case (op)
            NALU_ADD,
            NALU_SUB: result = sum[`NALU_W-1:0];
            NALU_AND: result = a & b;
            NALU_XOR: result = a ^ b;
            NALU_OR: result = a | b;
            default: result = sum[`NALU_W-1:0];
        endcase
    end
endmodule

// [hw/nalu_top.sv]
// Nibble arithmetic/logic datapath: accumulator, carry, index pointer
// Assumes decoder issues one op per exec pulse and memory read data
// for the addressed operand is valid in the same cycle as the pulse.
//
// Function
// - Indexed subtract write-back: mem + ~acc + 1 to acc and memory, carry updated.
// - Post-increment indexed forms do their work, then index pointer plus one, unless idx_load is high in the same cycle.
// - Add-keep-carry sums operands, memory or immediate, carry untouched.
// - Plain indexed add-keep-carry writes only the accumulator, memory unchanged.
// - Memory write-back forms store result in accumulator and addressed location.
// - Conjunction: memory AND accumulator into accumulator.
// - Exclusive disjunction: memory XOR accumulator into accumulator.
// - Inclusive disjunction: memory OR accumulator into accumulator.
// - Immediate add with carry in: reg + imm + carry, carry updated.
// - Immediate subtract with carry in: reg + ~imm + carry, carry updated.
// - Immediate add setting carry: reg + imm, no carry in.
// - Immediate subtract setting carry: reg + ~imm + 1, carry updated.
// - Immediate AND, XOR, OR of register and immediate into accumulator.
// - Immediate write-back forms store result in accumulator and working register.
// - Indexed operands read and written at address held in index pointer.
`timescale 1ns/1ns
`include "nalu_defs.svh"
module nalu_top
    import nalu_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Decoded instruction
    input wire logic exec,
    input wire nalu_op_t op,
    input wire nalu_src_t src,
    input wire nalu_cin_t cin_sel,
    input wire logic keep_carry,
    input wire logic write_back,
    input wire logic post_inc,
    input wire logic [`NALU_W-1:0] imm,
    input wire logic [`NALU_IDX_W-1:0] direct_addr,
    // Index pointer load
    input wire logic idx_load,
    input wire logic [`NALU_IDX_W-1:0] idx_load_val,
    // Data memory and working register operand
    input wire logic [`NALU_W-1:0] mem_rdata,
    input wire logic [`NALU_W-1:0] work_reg_operand,
    output logic [`NALU_IDX_W-1:0] mem_addr,
    output logic mem_we,
    output logic [`NALU_W-1:0] mem_wdata,
    output logic wr_we,
    output logic [`NALU_W-1:0] wr_wdata,
    // Architectural state
    output logic [`NALU_W-1:0] result_nibble_reg,
    output logic carry_bit,
    output logic [`NALU_IDX_W-1:0] index_pointer
);
    // ----------------------------------------
    // Operand select and ALU
    // ----------------------------------------
    logic go;
    logic is_imm;
    logic is_sub;
    logic alu_cin;
    logic alu_cout;
    logic [`NALU_W-1:0] alu_a;
    logic [`NALU_W-1:0] alu_b;
    logic [`NALU_W-1:0] alu_res;

    assign go = exec & clk_en;
    assign is_imm = (src == NALU_SRC_IMM);
    assign is_sub = (op == NALU_SUB);

    // Memory forms subtract the accumulator from the operand, so the
    // accumulator is the inverted side; immediates invert the immediate.
    assign alu_a = is_imm ? work_reg_operand : mem_rdata;
    assign alu_b = is_imm ? imm : result_nibble_reg;

    always_comb
    begin
        unique case (cin_sel)
            NALU_CIN_ONE: alu_cin = 1'b1;
            NALU_CIN_FLAG: alu_cin = carry_bit;
            default: alu_cin = 1'b0;
        endcase
    end

    nalu_core u_core
    (
        .op(op),
        .invert_b(is_sub),
        .cin(alu_cin),
        .a(alu_a),
        .b(alu_b),
        .result(alu_res),
        .cout(alu_cout)
    );

    // ----------------------------------------
    // Memory and register write strobes
    // ----------------------------------------
    // Indexed address follows the pointer; direct otherwise
    assign mem_addr = (src == NALU_SRC_INDEX) ? index_pointer : direct_addr;
    assign mem_we = go & write_back & ~is_imm;
    assign mem_wdata = alu_res;
    assign wr_we = go & write_back & is_imm;
    assign wr_wdata = alu_res;

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            result_nibble_reg <= `NALU_ZERO;
        else if (go)
            result_nibble_reg <= alu_res;
    end

    // ----------------------------------------
    // Carry
    // ----------------------------------------
    // Logic ops never touch carry; add-keep-carry holds it
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            carry_bit <= `NALU_CARRY_RST;
        else if (go && !keep_carry && (op == NALU_ADD || is_sub))
            carry_bit <= alu_cout;
    end

    // ----------------------------------------
    // Index pointer
    // ----------------------------------------
    // Increment uses the pre-op pointer, so the access hits the old address
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            index_pointer <= `NALU_IDX_RST;
        else if (clk_en)
        begin
            if (idx_load)
                index_pointer <= idx_load_val;
            else if (exec && post_inc && src == NALU_SRC_INDEX)
                index_pointer <= index_pointer + `NALU_IDX_ONE;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    logic [`NALU_W:0] chk_sub;
    assign chk_sub = {1'b0, mem_rdata} + {1'b0, ~result_nibble_reg} + {{`NALU_W{1'b0}}, 1'b1};

    sub_wb_value_a: assert property (
        go && op == NALU_SUB && src == NALU_SRC_INDEX && write_back && cin_sel == NALU_CIN_ONE
        |-> mem_we && mem_wdata == chk_sub[`NALU_W-1:0]
            ##1 result_nibble_reg == $past(chk_sub[`NALU_W-1:0]) && carry_bit == $past(chk_sub[`NALU_W]))
        else $error("indexed subtract write-back wrong");
    post_inc_step_a: assert property (
        clk_en && exec && post_inc && src == NALU_SRC_INDEX && !idx_load
        |=> index_pointer == $past(index_pointer) + `NALU_IDX_ONE)
        else $error("index pointer did not step");
    keep_carry_hold_a: assert property (
        go && keep_carry |=> $stable(carry_bit))
        else $error("carry changed on keep-carry add");
    no_wb_mem_a: assert property (
        exec && !write_back |-> !mem_we && !wr_we)
        else $error("write strobe without write-back");
    mem_wb_a: assert property (
        go && write_back && !is_imm |-> mem_we ##1 result_nibble_reg == $past(mem_wdata))
        else $error("memory write-back mismatch");
    logic_ops_a: assert property (
        go && !is_imm && op == NALU_AND |=> result_nibble_reg == ($past(mem_rdata) & $past(result_nibble_reg)))
        else $error("memory AND wrong");
    xor_mem_a: assert property (
        go && !is_imm && op == NALU_XOR |=> result_nibble_reg == ($past(mem_rdata) ^ $past(result_nibble_reg)))
        else $error("memory XOR wrong");
    or_mem_a: assert property (
        go && !is_imm && op == NALU_OR |=> result_nibble_reg == ($past(mem_rdata) | $past(result_nibble_reg)))
        else $error("memory OR wrong");
    imm_wb_a: assert property (
        go && is_imm && write_back
        |-> wr_we && !mem_we ##1 result_nibble_reg == $past(wr_wdata))
        else $error("working register write-back missing");
    index_addr_a: assert property (
        src == NALU_SRC_INDEX |-> mem_addr == index_pointer)
        else $error("indexed address not from pointer");

    // ----------------------------------------
    // Reference values
    // ----------------------------------------
    // Built from the raw operands, not the core outputs, so a slip in
    // operand select or inversion cannot agree with itself
    logic [`NALU_W:0] ref_add_flag;
    logic [`NALU_W:0] ref_sub_flag;
    logic [`NALU_W:0] ref_add_zero;
    logic [`NALU_W:0] ref_sub_one;
    logic [`NALU_W:0] ref_mem_add;
    assign ref_add_flag = {1'b0, work_reg_operand} + {1'b0, imm} + {`NALU_ZERO, carry_bit};
    assign ref_sub_flag = {1'b0, work_reg_operand} + {1'b0, ~imm} + {`NALU_ZERO, carry_bit};
    assign ref_add_zero = {1'b0, work_reg_operand} + {1'b0, imm};
    assign ref_sub_one = {1'b0, work_reg_operand} + {1'b0, ~imm} + {`NALU_ZERO, 1'b1};
    assign ref_mem_add = {1'b0, mem_rdata} + {1'b0, result_nibble_reg};

    // ----------------------------------------
    // Immediate forms
    // ----------------------------------------
    // Each carry-in source has its own check; a decoder that mixes
    // them up trips at least one of these
    imm_add_cin_a: assert property (
        go && is_imm && op == NALU_ADD && cin_sel == NALU_CIN_FLAG && !keep_carry
        |=> {carry_bit, result_nibble_reg} == $past(ref_add_flag))
        else $error("immediate add with carry in wrong");
    imm_sub_cin_a: assert property (
        go && is_imm && op == NALU_SUB && cin_sel == NALU_CIN_FLAG && !keep_carry
        |=> {carry_bit, result_nibble_reg} == $past(ref_sub_flag))
        else $error("immediate subtract with carry in wrong");
    imm_add_set_a: assert property (
        go && is_imm && op == NALU_ADD && cin_sel == NALU_CIN_ZERO && !keep_carry
        |=> {carry_bit, result_nibble_reg} == $past(ref_add_zero))
        else $error("immediate add setting carry wrong");
    imm_sub_set_a: assert property (
        go && is_imm && op == NALU_SUB && cin_sel == NALU_CIN_ONE && !keep_carry
        |=> {carry_bit, result_nibble_reg} == $past(ref_sub_one))
        else $error("immediate subtract setting carry wrong");
    imm_and_a: assert property (
        go && is_imm && op == NALU_AND |=> result_nibble_reg == ($past(work_reg_operand) & $past(imm)))
        else $error("immediate AND wrong");
    imm_xor_a: assert property (
        go && is_imm && op == NALU_XOR |=> result_nibble_reg == ($past(work_reg_operand) ^ $past(imm)))
        else $error("immediate XOR wrong");
    imm_or_a: assert property (
        go && is_imm && op == NALU_OR |=> result_nibble_reg == ($past(work_reg_operand) | $past(imm)))
        else $error("immediate OR wrong");
    imm_no_mem_a: assert property (
        go && is_imm |-> !mem_we)
        else $error("immediate form wrote data memory");

    // ----------------------------------------
    // Memory forms and carry
    // ----------------------------------------
    // Keep-carry must hold the flag across the op, not restore it later
    keep_sum_mem_a: assert property (
        go && !is_imm && op == NALU_ADD && keep_carry
        |=> result_nibble_reg == $past(ref_mem_add[`NALU_W-1:0]) && $stable(carry_bit))
        else $error("memory keep-carry sum wrong");
    keep_sum_imm_a: assert property (
        go && is_imm && op == NALU_ADD && keep_carry
        |=> result_nibble_reg == $past(ref_add_zero[`NALU_W-1:0]) && $stable(carry_bit))
        else $error("immediate keep-carry sum wrong");
    plain_keep_idx_a: assert property (
        go && src == NALU_SRC_INDEX && op == NALU_ADD && keep_carry && !write_back
        |-> !mem_we ##1 result_nibble_reg == $past(ref_mem_add[`NALU_W-1:0]))
        else $error("plain indexed keep-carry add touched memory");
    mem_add_carry_a: assert property (
        go && !is_imm && op == NALU_ADD && !keep_carry && cin_sel == NALU_CIN_ZERO
        |=> {carry_bit, result_nibble_reg} == $past(ref_mem_add))
        else $error("memory add carry out wrong");
    // Set carry after a subtract means no borrow was needed
    sub_mem_carry_a: assert property (
        go && !is_imm && op == NALU_SUB && cin_sel == NALU_CIN_ONE && !keep_carry
        |=> {carry_bit, result_nibble_reg} == $past(chk_sub))
        else $error("memory subtract carry out wrong");
    logic_no_carry_a: assert property (
        go && op inside {NALU_AND, NALU_XOR, NALU_OR} |=> $stable(carry_bit))
        else $error("logic op changed carry");
    mem_wb_data_a: assert property (
        go && write_back && !is_imm && op == NALU_SUB && cin_sel == NALU_CIN_ONE |-> mem_wdata == chk_sub[`NALU_W-1:0])
        else $error("memory write-back data wrong");

    // ----------------------------------------
    // Pointer and write strobes
    // ----------------------------------------
    // Pointer moves only on a load or an indexed post-increment step;
    // a load wins over a step, so loads are left out of the hold check
    ptr_hold_a: assert property (
        !idx_load && !(clk_en && exec && post_inc && src == NALU_SRC_INDEX) |=> $stable(index_pointer))
        else $error("index pointer moved without a step");
    post_inc_access_a: assert property (
        go && post_inc && src == NALU_SRC_INDEX && write_back
        |-> mem_we && mem_addr == index_pointer)
        else $error("post-increment form skipped its access");
    direct_addr_a: assert property (
        src == NALU_SRC_DIRECT |-> mem_addr == direct_addr)
        else $error("direct address not passed through");
    wb_one_target_a: assert property (
        go |-> !(mem_we && wr_we))
        else $error("both write strobes high");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    // Main paths the bench is expected to reach
    sub_wb_c: cover property (go && is_sub && write_back && src == NALU_SRC_INDEX);
    post_inc_c: cover property (go && post_inc && src == NALU_SRC_INDEX);
    imm_carry_c: cover property (go && is_imm && cin_sel == NALU_CIN_FLAG && alu_cout);
    keep_carry_c: cover property (go && keep_carry && write_back && src == NALU_SRC_INDEX);
    imm_logic_c: cover property (go && is_imm && op == NALU_XOR && write_back);
endmodule

// [verif/nalu_mem_model.sv]
// Data memory and working register model for the nibble ALU
// Assumes read data is combinational and writes land at the clock edge
`timescale 1ns/1ns
module nalu_mem_model
(
    // Clock
    input wire logic ref_clk,
    // Data memory
    input wire logic [7:0] mem_addr,
    input wire logic mem_we,
    input wire logic [3:0] mem_wdata,
    output logic [3:0] mem_rdata,
    // Working register
    input wire logic wr_we,
    input wire logic [3:0] wr_wdata,
    output logic [3:0] work_reg_operand
);
    logic [3:0] mem [256];
    // Scrambled contents so no two neighbours match
    initial
    begin
        foreach (mem[i]) mem[i] = 4'(i * 7);
        work_reg_operand = 4'h9;
    end
    assign mem_rdata = mem[mem_addr];
    always @(posedge ref_clk)
    begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (wr_we) work_reg_operand <= wr_wdata;
    end
endmodule

// [verif/tb.sv]
// Self-checking bench for the nibble ALU datapath
// Assumes nalu_mem_model stands in for memory and working register
`timescale 1ns/1ns
module tb
    import nalu_pkg::*;
;
    logic ref_clk = 0, arst_n = 0, clk_en = 1, exec = 0, keep_carry = 0;
    logic write_back = 0, post_inc = 0, idx_load = 0, mem_we, wr_we, carry_bit, cf = 0;
    nalu_op_t op = NALU_ADD;
    nalu_src_t src = NALU_SRC_DIRECT;
    nalu_cin_t cin_sel = NALU_CIN_ZERO;
    logic [3:0] imm = 0, mem_rdata, work_reg_operand, mem_wdata, wr_wdata, result_nibble_reg, acc = 0;
    logic [7:0] direct_addr = 0, idx_load_val = 0, mem_addr, index_pointer, ptr = 0;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    nalu_top dut (.ref_clk, .arst_n, .clk_en, .exec, .op, .src, .cin_sel, .keep_carry, .write_back,
        .post_inc, .imm, .direct_addr, .idx_load, .idx_load_val, .mem_rdata, .work_reg_operand, .mem_addr,
        .mem_we, .mem_wdata, .wr_we, .wr_wdata, .result_nibble_reg, .carry_bit, .index_pointer);
    nalu_mem_model mdl (.ref_clk, .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .wr_we, .wr_wdata,
        .work_reg_operand);
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(logic [7:0] g, logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // ----------------------------------------
    // One operation, expectation worked out here
    // ----------------------------------------
    task automatic run(nalu_op_t o, nalu_src_t s, nalu_cin_t c, logic kc, logic wb, logic pi, logic [3:0] im);
        logic [7:0] ad;
        logic [3:0] a, b, nb, old, oldw;
        logic [4:0] r;
        logic ci;
        ad = (s == NALU_SRC_INDEX) ? ptr : {4'h3, im};
        a = (s == NALU_SRC_IMM) ? work_reg_operand : mdl.mem[ad];
        b = (s == NALU_SRC_IMM) ? im : acc;
        nb = ~b;
        old = mdl.mem[ad];
        oldw = work_reg_operand;
        ci = (c == NALU_CIN_ONE) | ((c == NALU_CIN_FLAG) & cf);
        case (o)
            NALU_ADD: r = a + b + ci;
            NALU_SUB: r = a + nb + ci;
            NALU_AND: r = {cf, a & b};
            NALU_XOR: r = {cf, a ^ b};
            default: r = {cf, a | b};
        endcase
        @(posedge ref_clk);
        exec <= 1'b1;
        op <= o;
        src <= s;
        cin_sel <= c;
        keep_carry <= kc;
        write_back <= wb;
        post_inc <= pi;
        imm <= im;
        direct_addr <= {4'h3, im};
        @(negedge ref_clk);
        chk(mem_we, wb && s != NALU_SRC_IMM);
        chk(wr_we, wb && s == NALU_SRC_IMM);
        if (s != NALU_SRC_IMM) chk(mem_addr, ad);
        @(posedge ref_clk);
        exec <= 1'b0;
        acc = r[3:0];
        if (o inside {NALU_ADD, NALU_SUB} && !kc) cf = r[4];
        if (pi && s == NALU_SRC_INDEX) ptr = ptr + 8'h01;
        #1;
        chk(result_nibble_reg, acc);
        chk(carry_bit, cf);
        chk(index_pointer, ptr);
        if (s != NALU_SRC_IMM) chk(mdl.mem[ad], wb ? r[3:0] : old);
        else chk(work_reg_operand, wb ? r[3:0] : oldw);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sub_idx();
        @(posedge ref_clk);
        idx_load <= 1'b1;
        idx_load_val <= 8'hff;
        @(posedge ref_clk);
        idx_load <= 1'b0;
        ptr = 8'hff;
        run(NALU_SUB, NALU_SRC_INDEX, NALU_CIN_ONE, 0, 1, 1, 0);
        run(NALU_SUB, NALU_SRC_INDEX, NALU_CIN_ONE, 0, 1, 1, 0);
    endtask
    task automatic t_keep();
        run(NALU_ADD, NALU_SRC_INDEX, NALU_CIN_ZERO, 1, 0, 0, 0);
        run(NALU_ADD, NALU_SRC_INDEX, NALU_CIN_ZERO, 1, 1, 1, 0);
        run(NALU_ADD, NALU_SRC_IMM, NALU_CIN_ZERO, 1, 1, 0, 4'hf);
        run(NALU_ADD, NALU_SRC_DIRECT, NALU_CIN_ZERO, 0, 1, 0, 4'hb);
    endtask
    task automatic t_logic();
        nalu_op_t ops[3] = '{NALU_AND, NALU_XOR, NALU_OR};
        foreach (ops[i])
        begin
            run(ops[i], NALU_SRC_DIRECT, NALU_CIN_ZERO, 0, 1, 0, 4'(i * 5));
            run(ops[i], NALU_SRC_INDEX, NALU_CIN_ZERO, 0, 0, 1, 0);
            run(ops[i], NALU_SRC_IMM, NALU_CIN_ZERO, 0, i[0], 0, 4'hf - 4'(i));
        end
    endtask
    task automatic t_imm();
        for (int i = 0; i < 16; i += 5)
        begin
            run(NALU_ADD, NALU_SRC_IMM, NALU_CIN_FLAG, 0, 0, 0, 4'(i));
            run(NALU_SUB, NALU_SRC_IMM, NALU_CIN_FLAG, 0, 1, 0, 4'(i));
            run(NALU_ADD, NALU_SRC_IMM, NALU_CIN_ZERO, 0, 1, 0, 4'(15 - i));
            run(NALU_SUB, NALU_SRC_IMM, NALU_CIN_ONE, 0, 0, 0, 4'(i));
        end
    endtask
    task automatic t_hold();
        logic [3:0] old;
        old = mdl.mem[ptr];
        @(posedge ref_clk);
        clk_en <= 1'b0;
        exec <= 1'b1;
        op <= NALU_ADD;
        src <= NALU_SRC_INDEX;
        keep_carry <= 1'b0;
        write_back <= 1'b1;
        post_inc <= 1'b1;
        @(negedge ref_clk);
        chk(mem_we | wr_we, 0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        exec <= 1'b0;
        #1;
        chk({carry_bit, result_nibble_reg}, {cf, acc});
        chk(index_pointer, ptr);
        chk(mdl.mem[ptr], old);
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_sub_idx();
        t_keep();
        t_logic();
        t_imm();
        t_hold();
        close_out();
    end
endmodule
